// ==== design/gpbc_pkg.sv ====
package gpbc_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_PB_PIN   = 8'h00;
   localparam logic [7:0] OFS_PB_LAT   = 8'h04;
   localparam logic [7:0] OFS_PB_DIR   = 8'h08;
   localparam logic [7:0] OFS_ICTL     = 8'h0C;
   localparam logic [7:0] OFS_ICTL2    = 8'h10;
   localparam logic [7:0] OFS_ICTL3    = 8'h14;
   localparam logic [7:0] OFS_PC_PIN   = 8'h18;
   localparam logic [7:0] OFS_PC_LAT   = 8'h1C;
   localparam logic [7:0] OFS_PC_DIR   = 8'h20;
   localparam logic [7:0] OFS_CFG      = 8'h24;
   // reset values
   localparam logic [7:0] RST_DIR      = 8'hFF;
   localparam logic [7:0] RST_LAT      = 8'h00;
   localparam logic [7:0] RST_ICTL     = 8'h00;
   localparam logic [7:0] RST_ICTL2    = 8'hFF;
   localparam logic [7:0] RST_ICTL3    = 8'hC0;
   localparam logic [7:0] RST_CFG      = 8'h03;
   // interrupt_control_main fields
   localparam int B_CHG_FLAG  = 0;
   localparam int B_X0_FLAG   = 1;
   localparam int B_CHG_EN    = 3;
   localparam int B_X0_EN     = 4;
   // interrupt_control_edge_priority fields
   localparam int B_PU_DIS_N  = 7;
   localparam int B_EDG0      = 6;
   // interrupt_control_external fields (flags 0..2 for irq 1..3)
   localparam int B_X1_FLAG   = 0;
   // configuration register fields
   localparam int B_CC2_SEL   = 0;
   localparam int B_MCU_MODE  = 1;
   localparam int B_LVP_EN    = 2;
   localparam int B_SPROG     = 3;
   // pin positions
   localparam int PIN_CC2_B   = 3;
   localparam int PIN_CC2_C   = 1;
   localparam int PIN_LVP     = 5;
   localparam int PIN_PCLK    = 6;
   localparam int PIN_PDAT    = 7;
   localparam int CHG_LO      = 4;
   // peripheral override bundle for port c
   typedef struct packed {
      logic [7:0] force_out;
      logic [7:0] force_in;
      logic [7:0] data;
   } gpbc_ovr_t;
   // one driven signal with its enable
   typedef struct packed {
      logic oe;
      logic data;
   } gpbc_drv_t;
endpackage : gpbc_pkg

// ==== design/gpbc_top.sv ====
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Operation
// RULE_01: port c is eight bidirectional pins, each with its own direction bit.
// RULE_02: direction bit one puts the pin driver in high impedance.
// RULE_03: direction bit zero drives the pin from the output latch.
// RULE_04: the latch register reads back the stored value, not pin levels.
// RULE_05: an enabled peripheral may force a port c pin to output or input.
// RULE_06: peripheral overrides act on the pin only, never on the direction register.
// RULE_07: after power-on every port c pin is a digital input.
// RULE_08: latches kept on other resets; direction resets to all ones on every reset.
// RULE_09: port b bits 0..3 also act as external interrupt inputs 0..3.
// RULE_10: port b bits 4..7 provide interrupt-on-change.
// RULE_11: every port b pin has a software programmable weak pull-up.
// RULE_12: port b bits 5,6,7 serve low-voltage program enable, program clock, data.
// RULE_13: capture/compare 2 sits on b3 when selected outside mcu mode, else c1.
// RULE_14: default select value resolves to c1 because mcu mode resets set.
// RULE_15: b3 used as capture/compare 2 input feeds the capture input.
// RULE_16: c0 timer1 osc out/clock in, c1 osc in/capture_compare_2, c2 capture_compare_1/pwm.
// RULE_17: c3 serial clock, c4 serial data in, c5 serial data out.
// RULE_18: c6 usart transmit or clock, c7 usart receive or data.
// RULE_19: one active-low bit enables all pull-ups; off on outputs and after power-on.
// RULE_20: inputs b4..b7 compared with last-read value; mismatches set change flag.
// RULE_21: any port b access ends mismatch; persisting mismatch keeps setting the flag. Code ends it only on access to the port b pin register.
// RULE_22: software sets direction bits before using b0..b3 as interrupts.
// RULE_23: port registers read pin levels; latch registers read stored values.
// RULE_24: port b direction and latch behave as port c.
module gpbc_top
   import gpbc_pkg::*;
(
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // non power-on reset request
   input  wire logic        soft_rst_req,
   // port b pins
   input  wire logic [7:0]  pb_in,
   output logic      [7:0]  pb_out,
   output logic      [7:0]  pb_oe,
   output logic      [7:0]  pb_pullup,
   // port c pins
   input  wire logic [7:0]  pc_in,
   output logic      [7:0]  pc_out,
   output logic      [7:0]  pc_oe,
   // peripheral side
   input  wire gpbc_ovr_t   pc_ovr,
   input  wire gpbc_drv_t   cc2_drv,
   output logic             cc2_in,
   output logic      [7:0]  pc_periph_in,
   output logic      [2:0]  prog_pins
);

   logic [7:0]  pb_meta_reg, pb_sync_reg, pb_prev_reg;
   logic [7:0]  pc_meta_reg, pc_sync_reg;
   logic [7:0]  lat_b_reg, dir_b_reg, lat_c_reg, dir_c_reg;
   logic [7:0]  ictl_reg, ictl2_reg, ictl3_reg, cfg_reg;
   logic [3:0]  snap_reg;
   logic        wr_acc, pb_acc, addr_ok;
   logic [3:0]  mismatch;
   logic        cc2_on_b;
   logic [7:0]  pb_oe_next, pb_out_next, pb_pu_next, pc_oe_next, pc_out_next;
   logic [7:0]  rd_mux;
   logic [3:0]  ext_hit;

   // edge detector, rise selects rising edge
   function automatic logic edge_hit(input logic cur, input logic prev, input logic rise);
      edge_hit = rise ? (cur & ~prev) : (~cur & prev);
   endfunction : edge_hit

   // address decode
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFS_PB_PIN) || (a == OFS_PB_LAT) || (a == OFS_PB_DIR) ||
                  (a == OFS_ICTL) || (a == OFS_ICTL2) || (a == OFS_ICTL3) ||
                  (a == OFS_PC_PIN) || (a == OFS_PC_LAT) || (a == OFS_PC_DIR) ||
                  (a == OFS_CFG);
   endfunction : is_mapped

   // access phase strobes
   assign addr_ok = is_mapped(paddr);
   assign wr_acc  = psel & penable & pready & pwrite & pstrb[0] & addr_ok;
   assign pb_acc  = psel & penable & pready & (paddr == OFS_PB_PIN);       // [RULE_21]

   // two-flop input synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pb_meta_reg <= 8'h00;
         pb_sync_reg <= 8'h00;
         pb_prev_reg <= 8'h00;
         pc_meta_reg <= 8'h00;
         pc_sync_reg <= 8'h00;
      end else begin
         pb_meta_reg <= pb_in;
         pb_sync_reg <= pb_meta_reg;
         pb_prev_reg <= pb_sync_reg;
         pc_meta_reg <= pc_in;
         pc_sync_reg <= pc_meta_reg;
      end
   end

   // output latches: cleared only at power-on, kept over other resets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_b_reg <= RST_LAT;
         lat_c_reg <= RST_LAT;
      end else if (wr_acc) begin
         if (paddr == OFS_PB_PIN || paddr == OFS_PB_LAT) begin
            lat_b_reg <= pwdata[7:0];                                       // [RULE_04]
         end
         if (paddr == OFS_PC_PIN || paddr == OFS_PC_LAT) begin
            lat_c_reg <= pwdata[7:0];                                       // [RULE_04]
         end
      end
   end

   // direction registers: all ones on every reset, software only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_b_reg <= RST_DIR;                                              // [RULE_07]
         dir_c_reg <= RST_DIR;
      end else if (soft_rst_req) begin
         dir_b_reg <= RST_DIR;                                              // [RULE_08]
         dir_c_reg <= RST_DIR;
      end else if (wr_acc) begin
         if (paddr == OFS_PB_DIR) begin
            dir_b_reg <= pwdata[7:0];
         end
         if (paddr == OFS_PC_DIR) begin
            dir_c_reg <= pwdata[7:0];                                       // [RULE_06]
         end
      end
   end

   // pin mode configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= RST_CFG;                                                // [RULE_14]
      end else if (wr_acc && paddr == OFS_CFG) begin
         cfg_reg <= {4'h0, pwdata[3:0]};
      end
   end

   // edge and priority control; pull-up disable bit lives here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ictl2_reg <= RST_ICTL2;                                            // [RULE_19]
      end else if (soft_rst_req) begin
         ictl2_reg <= RST_ICTL2;
      end else if (wr_acc && paddr == OFS_ICTL2) begin
         ictl2_reg <= pwdata[7:0];
      end
   end

   // external interrupt edge events on b0..b3
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ext_hit[i] = edge_hit(pb_sync_reg[i], pb_prev_reg[i], ictl2_reg[B_EDG0 - i]); // [RULE_09]
      end
   end

   // interrupt-on-change compare against last-read snapshot
   assign mismatch = (pb_sync_reg[7:CHG_LO] ^ snap_reg) & dir_b_reg[7:CHG_LO]; // [RULE_20]

   // snapshot taken on any read or write of the port b pin register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_reg <= 4'h0;
      end else if (pb_acc) begin
         snap_reg <= pb_sync_reg[7:CHG_LO];                                 // [RULE_21]
      end
   end

   // main control: change flag and irq 0; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ictl_reg <= RST_ICTL;
      end else if (soft_rst_req) begin
         ictl_reg <= RST_ICTL;
      end else begin
         if (wr_acc && paddr == OFS_ICTL) begin
            ictl_reg <= pwdata[7:0];
         end
         if (|mismatch) begin
            ictl_reg[B_CHG_FLAG] <= 1'b1;                                   // [RULE_10] [RULE_21]
         end
         if (ext_hit[0]) begin
            ictl_reg[B_X0_FLAG] <= 1'b1;                                    // [RULE_09]
         end
      end
   end

   // external control: irq 1..3 flags; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ictl3_reg <= RST_ICTL3;
      end else if (soft_rst_req) begin
         ictl3_reg <= RST_ICTL3;
      end else begin
         if (wr_acc && paddr == OFS_ICTL3) begin
            ictl3_reg <= pwdata[7:0];
         end
         for (int i = 1; i < 4; i++) begin
            if (ext_hit[i]) begin
               ictl3_reg[B_X1_FLAG + i - 1] <= 1'b1;                        // [RULE_09]
            end
         end
      end
   end

   // capture/compare 2 placement
   assign cc2_on_b = cfg_reg[B_CC2_SEL] & ~cfg_reg[B_MCU_MODE];             // [RULE_13]

   // next pin drive for port b
   always_comb begin
      pb_oe_next  = ~dir_b_reg;                                             // [RULE_24]
      pb_out_next = lat_b_reg;
      if (cc2_on_b && cc2_drv.oe) begin
         pb_oe_next[PIN_CC2_B]  = 1'b1;
         pb_out_next[PIN_CC2_B] = cc2_drv.data;
      end
      if (cfg_reg[B_LVP_EN]) begin
         pb_oe_next[PIN_LVP] = 1'b0;                                        // [RULE_12]
      end
      if (cfg_reg[B_SPROG]) begin
         pb_oe_next[PIN_PCLK] = 1'b0;
         pb_oe_next[PIN_PDAT] = 1'b0;
      end
      pb_pu_next = {8{~ictl2_reg[B_PU_DIS_N]}} & ~pb_oe_next;               // [RULE_11] [RULE_19]
      if (cfg_reg[B_LVP_EN]) begin
         pb_pu_next[PIN_LVP] = 1'b0;
      end
   end

   // next pin drive for port c; forced input beats forced output
   always_comb begin
      pc_oe_next  = (~dir_c_reg | pc_ovr.force_out) & ~pc_ovr.force_in;    // [RULE_02] [RULE_05]
      pc_out_next = (lat_c_reg & ~pc_ovr.force_out) | (pc_ovr.data & pc_ovr.force_out); // [RULE_03]
      if (!cc2_on_b && cc2_drv.oe) begin
         pc_oe_next[PIN_CC2_C]  = 1'b1;                                     // [RULE_16]
         pc_out_next[PIN_CC2_C] = cc2_drv.data;
      end
   end

   // registered pin outputs and peripheral inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pb_oe        <= 8'h00;
         pb_out       <= 8'h00;
         pb_pullup    <= 8'h00;
         pc_oe        <= 8'h00;                                             // [RULE_07]
         pc_out       <= 8'h00;
         cc2_in       <= 1'b0;
         pc_periph_in <= 8'h00;
         prog_pins    <= 3'h0;
      end else begin
         pb_oe        <= pb_oe_next;
         pb_out       <= pb_out_next;
         pb_pullup    <= pb_pu_next;
         pc_oe        <= pc_oe_next;                                        // [RULE_01]
         pc_out       <= pc_out_next;
         cc2_in       <= cc2_on_b ? pb_sync_reg[PIN_CC2_B] : pc_sync_reg[PIN_CC2_C]; // [RULE_15]
         pc_periph_in <= pc_sync_reg;                                       // [RULE_17] [RULE_18]
         prog_pins    <= pb_sync_reg[PIN_PDAT:PIN_LVP];                     // [RULE_12]
      end
   end

   // read multiplexer
   always_comb begin
      unique case (paddr)
         OFS_PB_PIN: rd_mux = pb_sync_reg;                                  // [RULE_23]
         OFS_PB_LAT: rd_mux = lat_b_reg;                                    // [RULE_04]
         OFS_PB_DIR: rd_mux = dir_b_reg;
         OFS_ICTL:   rd_mux = ictl_reg;
         OFS_ICTL2:  rd_mux = ictl2_reg;
         OFS_ICTL3:  rd_mux = ictl3_reg;
         OFS_PC_PIN: rd_mux = pc_sync_reg;                                  // [RULE_23]
         OFS_PC_LAT: rd_mux = lat_c_reg;
         OFS_PC_DIR: rd_mux = dir_c_reg;
         OFS_CFG:    rd_mux = cfg_reg;
         default:    rd_mux = 8'h00;
      endcase
   end

   // apb answer: ready in the access cycle, data captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // ---- assertions ----
   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access_done;
      psel && penable && pready;
   endsequence

   property p_apb_ready;
      @(posedge pclk) disable iff (!presetn) s_setup |=> pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("pready missing in access");

   property p_dir_c_drive;
      @(posedge pclk) disable iff (!presetn)
         (pc_ovr == '0 && !cc2_drv.oe) ##1 (pc_ovr == '0 && !cc2_drv.oe) |-> pc_oe == ~$past(dir_c_reg);
   endproperty
   a_dir_c_drive: assert property (p_dir_c_drive) else $error("port c enable not from direction"); // [RULE_02]

   property p_lat_c_out;
      @(posedge pclk) disable iff (!presetn)
         (pc_ovr.force_out == 8'h00 && !cc2_drv.oe) |=> pc_out[7:2] == $past(lat_c_reg[7:2]);
   endproperty
   a_lat_c_out: assert property (p_lat_c_out) else $error("port c output not from latch"); // [RULE_03]

   property p_force_in;
      @(posedge pclk) disable iff (!presetn)
         (pc_ovr.force_in[0] && !(!cc2_on_b && cc2_drv.oe)) |=> !pc_oe[0];
   endproperty
   a_force_in: assert property (p_force_in) else $error("forced input still driven"); // [RULE_05]

   property p_ovr_not_stored;
      @(posedge pclk) disable iff (!presetn)
         !(wr_acc && paddr == OFS_PC_DIR) && !soft_rst_req |=> $stable(dir_c_reg);
   endproperty
   a_ovr_not_stored: assert property (p_ovr_not_stored) else $error("direction changed without write"); // [RULE_06]

   property p_soft_keep_lat;
      @(posedge pclk) disable iff (!presetn)
         soft_rst_req && !wr_acc |=> dir_b_reg == RST_DIR && $stable(lat_b_reg);
   endproperty
   a_soft_keep_lat: assert property (p_soft_keep_lat) else $error("soft reset handling wrong"); // [RULE_08]

   property p_pullup_off_out;
      @(posedge pclk) disable iff (!presetn) (pb_pullup & pb_oe) == 8'h00;
   endproperty
   a_pullup_off_out: assert property (p_pullup_off_out) else $error("pull-up on a driven pin"); // [RULE_19]

   property p_change_flag;
      @(posedge pclk) disable iff (!presetn) (|mismatch) && !soft_rst_req |=> ictl_reg[B_CHG_FLAG];
   endproperty
   a_change_flag: assert property (p_change_flag) else $error("change flag not set"); // [RULE_20]

   property p_snap_on_read;
      @(posedge pclk) disable iff (!presetn)
         s_access_done and (paddr == OFS_PB_PIN) |=> snap_reg == $past(pb_sync_reg[7:CHG_LO]);
   endproperty
   a_snap_on_read: assert property (p_snap_on_read) else $error("snapshot missed"); // [RULE_21]

   property p_ext0_flag;
      @(posedge pclk) disable iff (!presetn) ext_hit[0] && !soft_rst_req |=> ictl_reg[B_X0_FLAG];
   endproperty
   a_ext0_flag: assert property (p_ext0_flag) else $error("external irq 0 flag lost"); // [RULE_09]

   property p_pin_read;
      @(posedge pclk) disable iff (!presetn)
         s_setup and (paddr == OFS_PC_PIN) and !pwrite |=> prdata[7:0] == $past(pc_sync_reg);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("port c read not pin level"); // [RULE_23]

   property p_cc2_route;
      @(posedge pclk) disable iff (!presetn)
         cc2_on_b && cc2_drv.oe |=> pb_oe[PIN_CC2_B] && pb_out[PIN_CC2_B] == $past(cc2_drv.data);
   endproperty
   a_cc2_route: assert property (p_cc2_route) else $error("capture/compare 2 misrouted"); // [RULE_13]

endmodule : gpbc_top

// ==== dv/tb_gpbc_top.sv ====
`timescale 1ns/10ps
module tb_gpbc_top;
   import gpbc_pkg::*;
   // bench signals
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        soft_rst_req;
   logic [7:0]  pb_in;
   logic [7:0]  pb_out;
   logic [7:0]  pb_oe;
   logic [7:0]  pb_pullup;
   logic [7:0]  pc_in;
   logic [7:0]  pc_out;
   logic [7:0]  pc_oe;
   gpbc_ovr_t   pc_ovr;
   gpbc_drv_t   cc2_drv;
   logic        cc2_in;
   logic [7:0]  pc_periph_in;
   logic [2:0]  prog_pins;
   int          miscompares;
   int          check_count;
   int          cyc;
   logic [31:0] rnd;
   logic [7:0]  rd;
   logic        err;
   // behavioural model state
   int          m_lat_b;
   int          m_lat_c;
   int          m_dir_b;
   int          m_dir_c;

   gpbc_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .soft_rst_req(soft_rst_req), .pb_in(pb_in), .pb_out(pb_out),
      .pb_oe(pb_oe), .pb_pullup(pb_pullup), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
      .pc_ovr(pc_ovr), .cc2_drv(cc2_drv), .cc2_in(cc2_in), .pc_periph_in(pc_periph_in),
      .prog_pins(prog_pins)
   );

   // clock, 40 ns period
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         finish_test();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer, held until pready seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // wait for pready at a rising edge; the hang guard ends a stall
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd  = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk({24'h0, rd}, {24'h0, exp});
   endtask : rdchk

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   task automatic finish_test();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // main sequence
   initial begin
      miscompares = 0;
      check_count = 0;
      cyc = 0;
      rnd = 32'hF88B1310;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      soft_rst_req = 1'b0;
      pb_in = 8'h00;
      pc_in = 8'h00;
      pc_ovr = '0;
      cc2_drv = '0;
      idle(3);
      presetn <= 1'b1;
      idle(2);
      // reset values and power-on input state
      chk({pc_oe, pb_oe, pb_pullup}, 24'h000000);
      rdchk(OFS_PC_DIR, 8'hFF);
      rdchk(OFS_PB_DIR, 8'hFF);
      rdchk(OFS_ICTL, 8'h00);
      rdchk(OFS_ICTL2, 8'hFF);
      rdchk(OFS_ICTL3, 8'hC0);
      rdchk(OFS_CFG, RST_CFG);
      // random direction and latch values on both ports
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         m_lat_c = rnd[7:0];
         m_dir_c = rnd[15:8];
         m_lat_b = rnd[23:16];
         m_dir_b = rnd[31:24] | 8'h0F;
         pc_in <= rnd[15:8] ^ rnd[7:0];
         apb(1'b1, OFS_PC_LAT, m_lat_c[7:0]);
         apb(1'b1, OFS_PC_DIR, m_dir_c[7:0]);
         apb(1'b1, OFS_PB_LAT, m_lat_b[7:0]);
         apb(1'b1, OFS_PB_DIR, m_dir_b[7:0]);
         idle(4);
         chk(pc_oe, 8'(~m_dir_c[7:0]));
         chk(pc_out & pc_oe, m_lat_c[7:0] & ~m_dir_c[7:0]);
         chk(pb_oe, 8'(~m_dir_b[7:0]));
         chk(pb_out & pb_oe, m_lat_b[7:0] & ~m_dir_b[7:0]);
         rdchk(OFS_PC_LAT, m_lat_c[7:0]);
         rdchk(OFS_PB_LAT, m_lat_b[7:0]);
         rdchk(OFS_PC_PIN, rnd[15:8] ^ rnd[7:0]);
      end
      // peripheral override acts on pins only
      apb(1'b1, OFS_PC_DIR, 8'hF0);
      pc_ovr <= '{force_out: 8'h0F | 8'h30, force_in: 8'h81, data: 8'hA5};
      idle(3);
      chk(pc_oe, 8'h3E);
      chk(pc_out & 8'h3E, ((8'hA5 & 8'h3F) | (m_lat_c[7:0] & 8'hC0)) & 8'h3E);
      rdchk(OFS_PC_DIR, 8'hF0);
      pc_ovr <= '0;
      // non power-on reset keeps latches, restores directions
      soft_rst_req <= 1'b1;
      idle(2);
      soft_rst_req <= 1'b0;
      idle(2);
      rdchk(OFS_PC_DIR, 8'hFF);
      rdchk(OFS_PB_DIR, 8'hFF);
      rdchk(OFS_PC_LAT, m_lat_c[7:0]);
      chk(pc_oe, 8'h00);
      // pull-ups only on input pins when enabled
      apb(1'b1, OFS_PB_DIR, 8'h3C);
      apb(1'b1, OFS_ICTL2, 8'h7F);
      idle(2);
      chk(pb_pullup, 8'h3C);
      apb(1'b1, OFS_ICTL2, 8'hFF);
      idle(2);
      chk(pb_pullup, 8'h00);
      // interrupt-on-change on inputs b4..b7
      apb(1'b1, OFS_PB_DIR, 8'hFF);
      apb(1'b0, OFS_PB_PIN, 8'h00);
      apb(1'b1, OFS_ICTL, 8'h00);
      pb_in <= pb_in ^ 8'h20;
      idle(5);
      apb(1'b0, OFS_ICTL, 8'h00);
      chk(rd[B_CHG_FLAG], 1'b1);
      apb(1'b1, OFS_ICTL, 8'h00);
      apb(1'b0, OFS_ICTL, 8'h00);
      chk(rd[B_CHG_FLAG], 1'b1);
      apb(1'b0, OFS_PB_PIN, 8'h00);
      apb(1'b1, OFS_ICTL, 8'h00);
      apb(1'b0, OFS_ICTL, 8'h00);
      chk(rd[B_CHG_FLAG], 1'b0);
      // pins driven as outputs are excluded from the comparison
      apb(1'b1, OFS_PB_DIR, 8'h0F);
      apb(1'b0, OFS_PB_PIN, 8'h00);
      apb(1'b1, OFS_ICTL, 8'h00);
      pb_in <= pb_in ^ 8'hF0;
      idle(5);
      apb(1'b0, OFS_ICTL, 8'h00);
      chk(rd[B_CHG_FLAG], 1'b0);
      // capture/compare 2 moved to b3 outside mcu mode
      apb(1'b1, OFS_PB_DIR, 8'hFF);
      apb(1'b1, OFS_CFG, 8'h01);
      cc2_drv <= '{oe: 1'b1, data: 1'b1};
      pb_in <= 8'h08;
      idle(4);
      chk({pb_oe[PIN_CC2_B], pb_out[PIN_CC2_B], cc2_in}, 3'b111);
      pb_in <= 8'h00;
      idle(4);
      chk(cc2_in, 1'b0);
      apb(1'b1, OFS_CFG, RST_CFG);
      idle(3);
      chk({pb_oe[PIN_CC2_B], pc_oe[PIN_CC2_C]}, 2'b01);
      cc2_drv <= '0;
      // external irq edges, rising then falling; synced peripheral and program inputs
      apb(1'b1, OFS_ICTL3, RST_ICTL3);
      apb(1'b1, OFS_ICTL, 8'h00);
      pb_in <= 8'hAF;
      pc_in <= 8'h5A;
      idle(4);
      apb(1'b0, OFS_ICTL3, 8'h00);
      chk(rd[2:0], 3'h7);
      apb(1'b0, OFS_ICTL, 8'h00);
      chk(rd[B_X0_FLAG], 1'b1);
      chk(pc_periph_in, 8'h5A);
      chk(prog_pins, 3'h5);
      apb(1'b1, OFS_ICTL2, 8'h87);
      apb(1'b1, OFS_ICTL3, RST_ICTL3);
      pb_in <= 8'hA0;
      idle(4);
      apb(1'b0, OFS_ICTL3, 8'h00);
      chk(rd[2:0], 3'h7);
      // program modes release b5..b7 drivers and the b5 pull-up
      apb(1'b1, OFS_CFG, 8'h0F);
      apb(1'b1, OFS_PB_DIR, 8'h00);
      apb(1'b1, OFS_ICTL2, 8'h7F);
      idle(2);
      chk({pb_oe, pb_pullup}, 16'h1FC0);
      apb(1'b1, OFS_CFG, RST_CFG);
      apb(1'b1, OFS_ICTL2, RST_ICTL2);
      // unmapped address answers with an error and zero data
      apb(1'b0, 8'h30, 8'h00);
      chk({err, rd}, 9'h100);
      finish_test();
   end
endmodule : tb_gpbc_top
